/* core/i2c_arbitration_wakeup_reservation.sv */
// arbitration loss, wakeup filtering and start reservation with axi4-lite registers
`timescale 1ns/1ps
module i2c_arbitration_wakeup_reservation (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic serialClockIn,
    input wire logic serialDataIn,
    output logic serialClockOut,
    output logic serialClockOe,
    output logic serialDataOut,
    output logic serialDataOe,
    input wire i2c_arb_pkg::link_state_t linkState,
    output logic serialInterrupt,
    output logic waitRelease
);
    import i2c_arb_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_MASTER = 4'b0100,
        ST_WAIT = 4'b1000
    } master_state_t;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclLast;
        logic sdaLast;
        logic busBusy;
        logic startSeen;
        logic wakeStandby;
        logic arbLost;
        logic arbLostPend;
        logic masterStatus;
        logic startOutcome;
        logic reserved;
        logic addrWritten;
        logic [2:0] outcomeCnt;
        logic outcomePend;
        logic [5:0] ctrl;
        master_state_t mstate;
        logic sclOe;
        logic sdaOe;
        logic irq;
        logic waitRel;
        logic awTaken;
        logic wTaken;
        logic [7:0] wAddr;
        logic [31:0] wData;
        logic wStrb0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } state_t;

    state_t s_reg;
    state_t s_next;

    bus_events_t ev;
    logic wrFire;
    logic rdFire;
    logic busUnused;
    logic byteIrqEdge;
    logic lossSet;

    always_comb begin
        s_next = s_reg;
        ev = '0;
        wrFire = 1'b0;
        rdFire = 1'b0;
        lossSet = 1'b0;
        s_next.irq = 1'b0;
        s_next.waitRel = 1'b0;

        // [RQ22] two-stage sync before edge detection
        s_next.sclSync = {s_reg.sclSync[0], serialClockIn};
        s_next.sdaSync = {s_reg.sdaSync[0], serialDataIn};
        s_next.sclLast = s_reg.sclSync[1];
        s_next.sdaLast = s_reg.sdaSync[1];
        ev.startDetected = s_reg.sclSync[1] & s_reg.sdaLast & ~s_reg.sdaSync[1];
        ev.stopDetected = s_reg.sclSync[1] & ~s_reg.sdaLast & s_reg.sdaSync[1];
        ev.clockFall = s_reg.sclLast & ~s_reg.sclSync[1];
        ev.dataSample = s_reg.sdaSync[1];

        // [RQ20] loss or released extension code leaves bus unused by us
        busUnused = ~s_reg.masterStatus & ~linkState.isMaster
            & (~linkState.isSlave | s_reg.ctrl[CTL_BUS_RELEASE]);

        // [RQ7] ninth edge with wait timing 1, eighth for extension code with 0
        if (s_reg.ctrl[CTL_WAIT_TIMING]) begin
            byteIrqEdge = linkState.byteEnd9;
        end else begin
            byteIrqEdge = linkState.extCode ? linkState.byteEnd8 : linkState.byteEnd9;
        end

        if (ev.startDetected) begin
            s_next.busBusy = 1'b1;
            s_next.startSeen = 1'b1;
            // [RQ10] standby until the address phase ends
            s_next.wakeStandby = 1'b1;
        end
        if (linkState.byteEnd9) begin
            s_next.wakeStandby = 1'b0;
        end

        // [RQ9] slave interrupt only on own address or extension code
        if (linkState.isSlave && byteIrqEdge && (linkState.addrMatch || linkState.extCode)) begin
            s_next.irq = 1'b1;
        end

        // [RQ1] keep driving while our bits still agree
        if (s_reg.mstate == ST_MASTER && linkState.txDiffers) begin
            // [RQ2] flag at loss and release both lines
            s_next.arbLost = 1'b1;
            s_next.masterStatus = 1'b0;
            s_next.sclOe = 1'b0;
            s_next.sdaOe = 1'b0;
            s_next.mstate = ST_IDLE;
            s_next.arbLostPend = 1'b1;
            lossSet = 1'b1;
        end
        // [RQ6] restart/stop attempt losses report after the byte
        if (s_reg.mstate == ST_MASTER && (linkState.restartTry || linkState.stopTry)
            && (!ev.dataSample || (linkState.restartTry && !s_reg.sclSync[1]))) begin
            lossSet = 1'b1;
            s_next.arbLost = 1'b1;
            s_next.masterStatus = 1'b0;
            s_next.sclOe = 1'b0;
            s_next.sdaOe = 1'b0;
            s_next.mstate = ST_IDLE;
            s_next.arbLostPend = 1'b1;
        end
        // [RQ4] byte-phase loss interrupts at the chosen falling edge
        if (s_reg.arbLostPend && byteIrqEdge) begin
            s_next.irq = 1'b1;
            s_next.arbLostPend = 1'b0;
        end

        if (ev.stopDetected) begin
            s_next.busBusy = 1'b0;
            s_next.startSeen = 1'b0;
            s_next.wakeStandby = 1'b0;
            // [RQ5] stop-caused loss reported at stop only when enabled
            if (s_reg.mstate == ST_MASTER) begin
                lossSet = 1'b1;
                s_next.arbLost = 1'b1;
                s_next.masterStatus = 1'b0;
                s_next.sclOe = 1'b0;
                s_next.sdaOe = 1'b0;
                s_next.mstate = ST_IDLE;
            end
            // [RQ11] stop interrupt gated by enable alone
            if (s_reg.ctrl[CTL_STOP_IE]) begin
                s_next.irq = 1'b1;
                s_next.arbLostPend = 1'b0;
            end
            // [RQ15] reserved transfer waits for stop, then an address write
            if (s_reg.reserved) begin
                s_next.addrWritten = 1'b0;
                s_next.mstate = ST_WAIT;
            end
        end

        // [RQ19] outcome settles a few cycles after the request
        if (s_reg.outcomePend) begin
            if (s_reg.outcomeCnt == 3'(OUTCOME_CYCLES)) begin
                s_next.outcomePend = 1'b0;
                s_next.outcomeCnt = '0;
                s_next.ctrl[CTL_START_REQ] = 1'b0;
                if (!s_reg.busBusy) begin
                    // [RQ13] free bus: start then wait for data
                    s_next.startOutcome = 1'b0;
                    s_next.masterStatus = 1'b1;
                    s_next.sdaOe = 1'b1;
                    s_next.mstate = ST_START;
                end else if (!s_reg.ctrl[CTL_RSV_DISABLE] && s_reg.startSeen && busUnused) begin
                    // [RQ14] busy bus: record a reservation
                    // [RQ17] accepted between start and stop detection
                    s_next.reserved = 1'b1;
                    s_next.startOutcome = 1'b0;
                end else begin
                    // [RQ18] rejected, no start generated
                    // outcome flag high means the request was turned away
                    s_next.startOutcome = 1'b1;
                end
            end else begin
                s_next.outcomeCnt = s_reg.outcomeCnt + 3'd1;
            end
        end

        case (s_reg.mstate)
            ST_IDLE: begin
            end
            ST_START: begin
                s_next.sclOe = 1'b1;
                s_next.mstate = ST_WAIT;
            end
            ST_WAIT: begin
                if (s_reg.addrWritten) begin
                    s_next.addrWritten = 1'b0;
                    s_next.reserved = 1'b0;
                    s_next.masterStatus = 1'b1;
                    s_next.sdaOe = 1'b1;
                    s_next.sclOe = 1'b1;
                    s_next.mstate = ST_MASTER;
                    // [RQ21] data write ends the transmit wait
                    s_next.waitRel = 1'b1;
                end
            end
            ST_MASTER: begin
            end
            default: s_next.mstate = ST_IDLE;
        endcase

        // axi4-lite write
        if (awvalid && !s_reg.awTaken) begin
            s_next.awTaken = 1'b1;
            s_next.wAddr = awaddr;
        end
        if (wvalid && !s_reg.wTaken) begin
            s_next.wTaken = 1'b1;
            s_next.wData = wdata;
            // strobe kept with the data: the master may change it once taken
            s_next.wStrb0 = wstrb[0];
        end
        if (s_reg.awTaken && s_reg.wTaken && !s_reg.bValid) begin
            wrFire = 1'b1;
            s_next.awTaken = 1'b0;
            s_next.wTaken = 1'b0;
            s_next.bValid = 1'b1;
            s_next.bResp = RESP_OKAY;
            case (s_reg.wAddr)
                CTRL_OFFSET: begin
                    if (s_reg.wStrb0) begin
                        s_next.ctrl = s_reg.wData[5:0];
                        if (s_reg.wData[CTL_START_REQ] && !s_reg.outcomePend) begin
                            s_next.outcomePend = 1'b1;
                            s_next.outcomeCnt = '0;
                            s_next.startOutcome = 1'b0;
                        end
                    end
                end
                STATUS_OFFSET: begin
                    s_next.arbLost = 1'b0;
                end
                SHIFT_OFFSET: begin
                    // [RQ15] writes before the stop is seen are ignored
                    if (s_reg.mstate == ST_WAIT) begin
                        s_next.addrWritten = 1'b1;
                    end
                end
                FLAG_OFFSET: begin
                end
                default: s_next.bResp = RESP_SLVERR;
            endcase
        end
        if (s_reg.bValid && bready) begin
            s_next.bValid = 1'b0;
        end
        // hardware set wins over a same-cycle software clear
        if (wrFire && lossSet) begin
            s_next.arbLost = 1'b1;
        end

        // axi4-lite read
        if (arvalid && !s_reg.rValid) begin
            rdFire = 1'b1;
            s_next.rValid = 1'b1;
            s_next.rResp = RESP_OKAY;
            s_next.rData = '0;
            case (araddr)
                CTRL_OFFSET: s_next.rData = {26'h000_0000, s_reg.ctrl};
                STATUS_OFFSET: s_next.rData = {24'h00_0000, s_reg.masterStatus, 4'h0,
                    s_reg.arbLost, s_reg.startSeen, s_reg.wakeStandby};
                FLAG_OFFSET: s_next.rData = {24'h00_0000, s_reg.startOutcome, s_reg.busBusy,
                    4'h0, s_reg.reserved, s_reg.ctrl[CTL_RSV_DISABLE]};
                SHIFT_OFFSET: s_next.rData = '0;
                default: s_next.rResp = RESP_SLVERR;
            endcase
        end
        if (s_reg.rValid && rready) begin
            s_next.rValid = 1'b0;
        end

        // [RQ12] wakeup: only address/extension-code match and stop interrupts pass until software clears it
        // [RQ11] stop interrupt follows its enable, wakeup or not
        if (s_reg.ctrl[CTL_WAKEUP] && !(linkState.isSlave && byteIrqEdge
            && (linkState.addrMatch || linkState.extCode))
            && !(ev.stopDetected && s_reg.ctrl[CTL_STOP_IE])) begin
            s_next.irq = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.sclSync <= 2'b11;
            s_reg.sdaSync <= 2'b11;
            s_reg.sclLast <= 1'b1;
            s_reg.sdaLast <= 1'b1;
            s_reg.ctrl <= CTRL_RESET[5:0];
            s_reg.mstate <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = ~s_reg.awTaken;
    assign wready = ~s_reg.wTaken;
    assign bvalid = s_reg.bValid;
    assign bresp = s_reg.bResp;
    assign arready = ~s_reg.rValid;
    assign rvalid = s_reg.rValid;
    assign rdata = s_reg.rData;
    assign rresp = s_reg.rResp;
    // open-drain: drive low while enabled
    assign serialClockOut = 1'b0;
    assign serialDataOut = 1'b0;
    assign serialClockOe = s_reg.sclOe;
    assign serialDataOe = s_reg.sdaOe;
    assign serialInterrupt = s_reg.irq;
    assign waitRelease = s_reg.waitRel;
endmodule

/* inc/i2c_arb_pkg.sv */
// constants, register map and carrier types for the i2c arbitration/reservation block
//
// Summary of operation
// [RQ1] keep clocking and comparing bits during simultaneous starts until data differs
// [RQ2] on loss set loss flag at once and release clock and data lines
// [RQ3] software sees loss at next interrupt by reading loss flag
// [RQ4] loss in address, data or ack interrupts at eighth or ninth falling edge
// [RQ5] loss by stop detection interrupts at stop, only with stop interrupt enabled
// [RQ6] loss by low data or clock during restart/stop interrupts after byte
// [RQ7] wait timing 1 gives ninth edge; 0 with extension code gives eighth
// [RQ8] software should enable stop interrupt when multi-master arbitration is possible
// [RQ9] slave interrupts only on own address or extension code match
// [RQ10] start detection enters wakeup standby through the address phase
// [RQ11] stop interrupt depends only on stop interrupt enable
// [RQ12] wakeup bit set: interrupt on address match; software clears bit
// [RQ13] reservation enabled and bus free: start request generates start, then waits
// [RQ14] start request with reservation enabled: start if free, otherwise reserve
// [RQ15] after stop interrupt, address write starts reserved master transfer
// [RQ16] software waits width settings plus four clocks before reading master status
// [RQ17] reservation accepted between start detected and stop detected
// [RQ18] reservation disabled and bus busy: start request rejected, no start
// [RQ19] start outcome flag set within five clocks of start request
// [RQ20] arbitration loss or released extension code counts as bus unused
// [RQ21] shift register write ends a transmit-side wait
// [RQ22] start and stop detection synchronised before updating status bits
package i2c_arb_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] FLAG_OFFSET = 8'h08;
    localparam logic [7:0] SHIFT_OFFSET = 8'h0C;
    // control fields
    localparam int CTL_START_REQ = 0;
    localparam int CTL_WAIT_TIMING = 1;
    localparam int CTL_STOP_IE = 2;
    localparam int CTL_BUS_RELEASE = 3;
    localparam int CTL_WAKEUP = 4;
    localparam int CTL_RSV_DISABLE = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int OUTCOME_CYCLES = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic startDetected;
        logic stopDetected;
        logic clockFall;
        logic dataSample;
    } bus_events_t;

    typedef struct packed {
        logic isMaster;
        logic isSlave;
        logic addrMatch;
        logic extCode;
        logic byteEnd8;
        logic byteEnd9;
        logic txDiffers;
        logic restartTry;
        logic stopTry;
    } link_state_t;
endpackage

/* tb/i2c_arb_props.sv */
// port-level checks for the arbitration and reservation block
`timescale 1ns/1ps
module i2c_arb_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic serialClockOut,
    input wire logic serialClockOe,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire i2c_arb_pkg::link_state_t linkState,
    input wire logic serialInterrupt,
    input wire logic waitRelease
);
    import i2c_arb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_loss;
        linkState.isMaster && linkState.txDiffers;
    endsequence
    property p_loss_release;
        s_loss |-> ##[1:2] (!serialClockOe && !serialDataOe);
    endproperty
    a_loss_release: assert property (p_loss_release) else $error("bus not released after loss");
    property p_open_drain;
        !serialClockOut && !serialDataOut;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_irq_pulse;
        serialInterrupt |=> !serialInterrupt;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
    property p_nomatch;
        linkState.isSlave && !linkState.isMaster && !linkState.addrMatch && !linkState.extCode
            && linkState.byteEnd9 |=> !serialInterrupt;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("interrupt on address mismatch");
    property p_wait_pulse;
        waitRelease |=> !waitRelease;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("wait release longer than one cycle");
    property p_bhold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_arready;
        arready == !rvalid;
    endproperty
    a_arready: assert property (p_arready) else $error("read address ready wrong");
    property p_wr_resp;
        s_wr_taken |-> ##[1:3] bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_rd_resp;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
endmodule
bind i2c_arbitration_wakeup_reservation i2c_arb_props u_props (.clk, .resetn, .awvalid, .awready, .wvalid,
    .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .serialClockOut,
    .serialClockOe, .serialDataOut, .serialDataOe, .linkState, .serialInterrupt, .waitRelease);

/* tb/i2c_peer_model.sv */
// another master on the bus: makes start and stop conditions on pulled-up lines
`timescale 1ns/1ps
module i2c_peer_model (
    input wire logic sclPullLow,
    input wire logic sdaPullLow,
    output logic sclLine,
    output logic sdaLine
);
    logic sclDrive = 1'b1;
    logic sdaDrive = 1'b1;
    // pull-ups: a released line reads high, and the clock stands still between frames
    assign sclLine = sclDrive & !sclPullLow;
    assign sdaLine = sdaDrive & !sdaPullLow;
    task automatic send_start();
        sdaDrive = 1'b0;
        #400;
        sclDrive = 1'b0;
        #400;
    endtask
    task automatic send_stop();
        sclDrive = 1'b1;
        #400;
        sdaDrive = 1'b1;
        #400;
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for arbitration, wakeup and start reservation
`timescale 1ns/1ps
module tb_top;
    import i2c_arb_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, serialClockOut, serialClockOe, serialDataOut, serialDataOe;
    logic serialInterrupt, waitRelease, serialClockIn, serialDataIn;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    link_state_t linkState = '0;
    int bad_count = 0;
    int checks_done = 0;
    logic sawIrq, sawSda, sawRel;

    initial forever #50 clk = ~clk;

    i2c_arbitration_wakeup_reservation u_dut (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .serialClockIn, .serialDataIn, .serialClockOut, .serialClockOe, .serialDataOut,
        .serialDataOe, .linkState, .serialInterrupt, .waitRelease);
    i2c_peer_model u_peer (.sclPullLow(serialClockOe), .sdaPullLow(serialDataOe), .sclLine(serialClockIn),
        .sdaLine(serialDataIn));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        linkState <= '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask
    // handshake values are looked at on the falling edge, where they equal what the next rising edge takes
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta, tw, done = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) check(32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ta, done = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) check(32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic watch(input int n);
        sawIrq = 1'b0;
        sawSda = 1'b0;
        sawRel = 1'b0;
        repeat (n) begin
            @(negedge clk);
            sawIrq = sawIrq | serialInterrupt;
            sawSda = sawSda | serialDataOe;
            sawRel = sawRel | waitRelease;
        end
    endtask
    task automatic byte_end(input bit nine);
        @(posedge clk);
        linkState.byteEnd9 <= nine;
        linkState.byteEnd8 <= !nine;
        @(posedge clk);
        linkState.byteEnd9 <= 1'b0;
        linkState.byteEnd8 <= 1'b0;
        watch(4);
    endtask
    task automatic free_bus();
        do_reset();
        u_peer.send_start();
        u_peer.send_stop();
        watch(6);
    endtask

    task automatic t_regs();
        do_reset();
        axi_read(CTRL_OFFSET, rd, rs);
        check(rd, CTRL_RESET);
        axi_write(8'h10, 32'h0000_0000, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        axi_read(8'h10, rd, rs);
        check(32'(rs), 32'(RESP_SLVERR));
    endtask
    // the stop interrupt can come before the peer finishes, so watch alongside it
    task automatic stop_watch();
        fork
            u_peer.send_stop();
            watch(14);
        join
    endtask
    task automatic t_start_free();
        free_bus();
        axi_write(CTRL_OFFSET, 32'h0000_0001, rs);
        watch(8);
        check(32'(sawSda), 32'h0000_0001);
        axi_read(FLAG_OFFSET, rd, rs);
        check(32'(rd[7]), 32'h0000_0000);
    endtask
    task automatic t_reserve();
        do_reset();
        // multi-master use keeps the stop interrupt on
        axi_write(CTRL_OFFSET, 32'h0000_0004, rs);
        u_peer.send_start();
        watch(6);
        axi_write(CTRL_OFFSET, 32'h0000_0005, rs);
        // software waits before looking at the outcome
        watch(8);
        check(32'(sawSda), 32'h0000_0000);
        axi_read(FLAG_OFFSET, rd, rs);
        check(32'(rd[1]), 32'h0000_0001);
        check(32'(rd[7]), 32'h0000_0000);
        axi_write(SHIFT_OFFSET, 32'h0000_00a0, rs);
        watch(6);
        check(32'(sawSda), 32'h0000_0000);
        stop_watch();
        check(32'(sawIrq), 32'h0000_0001);
        axi_write(SHIFT_OFFSET, 32'h0000_00a0, rs);
        watch(8);
        check(32'(sawSda), 32'h0000_0001);
        check(32'(sawRel), 32'h0000_0001);
    endtask
    task automatic t_reject();
        do_reset();
        axi_write(CTRL_OFFSET, 32'h0000_0020, rs);
        u_peer.send_start();
        watch(6);
        axi_write(CTRL_OFFSET, 32'h0000_0021, rs);
        watch(5);
        check(32'(sawSda), 32'h0000_0000);
        axi_read(FLAG_OFFSET, rd, rs);
        check(32'(rd[7]), 32'h0000_0001);
        stop_watch();
        check(32'(sawIrq), 32'h0000_0000);
    endtask
    task automatic t_loss();
        free_bus();
        axi_write(CTRL_OFFSET, 32'h0000_0007, rs);
        watch(8);
        // the address write moves the started master into its transfer
        axi_write(SHIFT_OFFSET, 32'h0000_00a0, rs);
        // the winning master keeps both lines low across our release
        u_peer.send_start();
        @(posedge clk);
        linkState.isMaster <= 1'b1;
        linkState.txDiffers <= 1'b1;
        @(posedge clk);
        linkState.txDiffers <= 1'b0;
        linkState.isMaster <= 1'b0;
        watch(3);
        check({serialClockOe, serialDataOe}, 32'h0000_0000);
        check(32'(sawIrq), 32'h0000_0000);
        axi_read(STATUS_OFFSET, rd, rs);
        check(32'(rd[2]), 32'h0000_0001);
        byte_end(1'b0);
        check(32'(sawIrq), 32'h0000_0000);
        byte_end(1'b1);
        check(32'(sawIrq), 32'h0000_0001);
        axi_write(CTRL_OFFSET, 32'h0000_0004, rs);
        linkState.isSlave <= 1'b1;
        linkState.extCode <= 1'b1;
        byte_end(1'b0);
        check(32'(sawIrq), 32'h0000_0001);
        stop_watch();
        check(32'(sawIrq), 32'h0000_0001);
    endtask
    task automatic t_wakeup();
        do_reset();
        u_peer.send_start();
        watch(6);
        axi_read(STATUS_OFFSET, rd, rs);
        check(32'(rd[0]), 32'h0000_0001);
        linkState.isSlave <= 1'b1;
        byte_end(1'b1);
        check(32'(sawIrq), 32'h0000_0000);
        axi_write(CTRL_OFFSET, 32'h0000_0010, rs);
        linkState.addrMatch <= 1'b1;
        byte_end(1'b1);
        check(32'(sawIrq), 32'h0000_0001);
        axi_write(CTRL_OFFSET, 32'h0000_0000, rs);
        byte_end(1'b1);
        check(32'(sawIrq), 32'h0000_0001);
        axi_write(CTRL_OFFSET, 32'h0000_0014, rs);
        stop_watch();
        check(32'(sawIrq), 32'h0000_0001);
    endtask

    initial begin
        #4_000_000;
        bad_count++;
        results();
    end
    initial begin
        t_regs();
        t_start_free();
        t_reserve();
        t_reject();
        t_loss();
        t_wakeup();
        results();
    end
endmodule
